// ===== inc/pvs_pkg.sv
// Constants for the parallel video source that drives the display controller input.
// How it works
// RL1: vertical sync stays high one full line
// RL2: two or more lines of vertical back porch
// RL3: one or more lines of vertical front porch
// RL4: blanking at least 6 plus 8 times ratio
// RL5: horizontal sync high 4 to 128 clocks
// RL6: four or more clocks before data valid
// RL7: eight or more clocks after data valid
// RL8: all pins change away from sampling edge; eye select is not tied to pix_en and can change on the pclk rise
// RL9: eye select settles 1 ms before sync edge
// RL10: eye select held 1 ms after sync edge
// RL11: device counts active lines between vertical syncs
`default_nettype none
package pvs_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int PIX_W = 24;
   localparam int HW = 8;
   localparam int VW = 6;
   localparam int QW = 17;
   // Pixel clock is the system clock divided by four, high for two cycles.
   localparam logic [1:0] PCLK_DIV_LAST = 2'h3;
   localparam logic [1:0] PCLK_HALF = 2'h2;
   // Horizontal timing in pixel clocks.
   localparam int H_SYNC = 8;
   localparam int H_BP = 4;
   localparam int H_ACTIVE = 16;
   localparam int H_FP = 8;
   localparam logic [HW-1:0] H_SYNC_END = HW'(H_SYNC);
   localparam logic [HW-1:0] H_DV_ON = HW'(H_SYNC + H_BP);
   localparam logic [HW-1:0] H_DV_OFF = HW'(H_SYNC + H_BP + H_ACTIVE);
   localparam logic [HW-1:0] H_LAST = HW'(H_SYNC + H_BP + H_ACTIVE + H_FP - 1);
   // Vertical timing in lines.
   localparam int V_SYNC = 1;
   localparam int V_ACTIVE = 8;
   localparam int MIRROR_LINES = 4;
   localparam int V_RATIO = (V_ACTIVE + MIRROR_LINES - 1) / MIRROR_LINES;
   localparam int V_BLANK_MIN = 6 + 8 * ((V_RATIO > 1) ? V_RATIO : 1);
   localparam int V_FP = 1;
   localparam int V_BP = V_BLANK_MIN - V_FP;
   localparam logic [VW-1:0] V_SYNC_END = VW'(V_SYNC);
   localparam logic [VW-1:0] V_ACT_ON = VW'(V_BP);
   localparam logic [VW-1:0] V_ACT_OFF = VW'(V_BP + V_ACTIVE);
   localparam logic [VW-1:0] V_LAST = VW'(V_BP + V_ACTIVE + V_FP - 1);
   // Eye select guard time around each vertical sync transition.
   localparam int EYE_GUARD_NS = 1_000_000;
   localparam int EYE_GUARD_CYC = EYE_GUARD_NS / 1000 * (CLK_HZ / 1_000_000);
endpackage : pvs_pkg
`default_nettype wire

// ===== rtl/pvs_buf2.sv
// Two-entry buffer between the pixel producer and the video timing logic.
`default_nettype none
module pvs_buf2
   import pvs_pkg::*;
#(
   parameter int W = PIX_W
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic [W-1:0] mem_reg [2];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;

   // Occupancy; ready is registered so it is known a cycle ahead.
   assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
   assign out_data_o = mem_reg[rd_ptr_reg];

   ////////////////////////////////////////////////////////////////////////////////
   // Pointers and flags.
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg <= 2'h0;
         in_ready_o <= 1'b0;
         out_valid_o <= 1'b0;
      end
      else
      begin
         wr_ptr_reg <= wr_ptr_reg ^ push;
         rd_ptr_reg <= rd_ptr_reg ^ pop;
         cnt_reg <= cnt_next;
         in_ready_o <= (cnt_next != 2'h2);
         out_valid_o <= (cnt_next != 2'h0);
      end
   end

   // Storage has no reset; it is only read while valid.
   always_ff @(posedge clk_i)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end
endmodule : pvs_buf2
`default_nettype wire

// ===== rtl/pvs_video_source.sv
// Parallel video source: pixel clock, sync, data valid, pixel bus and eye select.
`default_nettype none
module pvs_video_source
   import pvs_pkg::*;
#(
   parameter int EYE_HOLD_CYC = EYE_GUARD_CYC
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic eye_select_i,
   input wire logic pix_valid_i,
   output logic pix_ready_o,
   input wire logic [PIX_W-1:0] pix_data_i,
   output logic pclk_o,
   output logic vsync_o,
   output logic hsync_o,
   output logic pixel_valid_in_o,
   output logic [PIX_W-1:0] pixel_bus_in_o,
   output logic stereo_eye_select_o,
   output logic underrun_o
);
   typedef enum logic {ST_IDLE, ST_RUN} pvs_state_t;

   localparam logic [QW-1:0] EYE_HOLD = QW'(EYE_HOLD_CYC);

   ////////////////////////////////////////////////////////////////////////////////
   // Timing overview. Sync, valid and bus pins are registered and move only on the pix_en cycle; eye select is not.
   // A line is H_LAST + 1 pixel clocks: sync first, then the back porch, the
   // data valid window, and the front porch that runs into the next sync.
   // A frame is V_LAST + 1 lines: the sync line, the back porch lines, the
   // active lines and one front porch line. Back plus front porch equals the
   // blanking floor, so the vertical geometry has no spare margin to lose.
   // The geometry is fixed at build time; another source resolution needs new
   // package constants rather than a register write.

   // Frame state, position counters, eye guard and the buffer's drain side.
   pvs_state_t state_reg;
   pvs_state_t state_next;
   logic [1:0] div_reg;
   logic [HW-1:0] h_reg;
   logic [HW-1:0] h_next;
   logic [VW-1:0] v_reg;
   logic [VW-1:0] v_next;
   logic [QW-1:0] quiet_reg;
   logic last_eye_reg;
   logic buf_valid;
   logic [PIX_W-1:0] buf_data;

   ////////////////////////////////////////////////////////////////////////////////
   // Pixel clock divider. Sync, valid and bus updates happen on the pix_en cycle, which is
   // the same edge where pclk falls, so the device's rising edge sits mid-bit.
   wire pix_en = (div_reg == PCLK_HALF - 2'h1); // [RL8]

   // The pixel clock resets high so its first fall lands on the first pix_en cycle.
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         div_reg <= 2'h0;
         pclk_o <= 1'b1;
      end
      else
      begin
         div_reg <= (div_reg == PCLK_DIV_LAST) ? 2'h0 : div_reg + 2'h1;
         pclk_o <= (div_reg == PCLK_DIV_LAST) | (div_reg < PCLK_HALF - 2'h1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Eye select guard. quiet_reg counts cycles since the last vertical sync
   // edge or eye change, saturating at the guard time.
   // The guard does not cover reset: the counter starts saturated.
   // Limitation: the request is a level, compared with the pin each cycle, so
   // a pulse on eye_select_i that ends while the guard is pending is lost.
   // Sync line of the next position, read here and by the pin registers.
   wire run_next = (state_next == ST_RUN);
   wire vs_line = run_next & (v_next < V_SYNC_END); // [RL1]
   wire vs_edge = pix_en & (vsync_o != vs_line);
   wire eye_want = (eye_select_i != stereo_eye_select_o);
   // Change only with sync low and the post-edge hold already served.
   wire eye_go = eye_want & ~vsync_o & ~vs_line & (quiet_reg >= EYE_HOLD); // [RL10]
   // A new frame may not begin until a fresh eye value has settled.
   wire start_ok = enable_i & (~last_eye_reg | (quiet_reg >= EYE_HOLD)); // [RL9]

   // A vertical sync edge restarts the guard ahead of any pending request.
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         quiet_reg <= EYE_HOLD;
         last_eye_reg <= 1'b0;
         stereo_eye_select_o <= 1'b0;
      end
      else if (vs_edge)
      begin
         quiet_reg <= {QW{1'b0}};
         last_eye_reg <= 1'b0;
      end
      else if (eye_go)
      begin
         quiet_reg <= {QW{1'b0}};
         last_eye_reg <= 1'b1;
         stereo_eye_select_o <= eye_select_i;
      end
      else if (quiet_reg < EYE_HOLD)
      begin
         quiet_reg <= quiet_reg + {{(QW-1){1'b0}}, 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame position. The frame ends after the last front porch line; if the
   // next frame may not start yet the source idles with all lines low, which
   // only lengthens the front porch.
   // Limitation: enable_i is only looked at between frames, so clearing it
   // lets the current frame finish rather than cutting it short.
   wire h_end = (h_reg == H_LAST);
   wire f_end = h_end & (v_reg == V_LAST);

   always_comb
   begin
      state_next = state_reg;
      h_next = h_reg;
      v_next = v_reg;
      case (state_reg)
         ST_IDLE:
         begin
            // Restart at the sync line so a new frame always opens with vsync.
            if (start_ok)
            begin
               state_next = ST_RUN;
               h_next = {HW{1'b0}};
               v_next = {VW{1'b0}};
            end
         end
         ST_RUN:
         begin
            h_next = h_end ? {HW{1'b0}} : h_reg + {{(HW-1){1'b0}}, 1'b1};
            v_next = h_end ? v_reg + {{(VW-1){1'b0}}, 1'b1} : v_reg;
            // The frame wraps or parks here, never in the middle of a line.
            if (f_end)
            begin
               state_next = start_ok ? ST_RUN : ST_IDLE;
               v_next = {VW{1'b0}};
            end
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Position registers advance once per pixel clock.
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_IDLE;
         h_reg <= {HW{1'b0}};
         v_reg <= {VW{1'b0}};
      end
      else if (pix_en)
      begin
         state_reg <= state_next;
         h_reg <= h_next;
         v_reg <= v_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin decode from the next position, so the registered pins line up with
   // the counters. The active lines sit after the back porch, and the front
   // porch plus back porch meet the blanking floor set in the package.
   wire hs_next = run_next & (h_next < H_SYNC_END); // [RL5]
   wire act_line = (v_next >= V_ACT_ON) & (v_next < V_ACT_OFF); // [RL2] [RL3] [RL4]
   wire dv_next = run_next & act_line & (h_next >= H_DV_ON) & (h_next < H_DV_OFF); // [RL6] [RL7]
   // A pixel slot consumes a word only when one is buffered; an empty buffer sends black.
   wire take = dv_next & buf_valid;

   // Pin registers. Underrun is a single clock pulse, not sticky, so a monitor
   // that wants a count must accumulate it itself.
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         vsync_o <= 1'b0;
         hsync_o <= 1'b0;
         pixel_valid_in_o <= 1'b0;
         pixel_bus_in_o <= {PIX_W{1'b0}};
         underrun_o <= 1'b0;
      end
      else
      begin
         underrun_o <= pix_en & dv_next & ~buf_valid;
         if (pix_en)
         begin
            vsync_o <= vs_line; // [RL8]
            hsync_o <= hs_next;
            pixel_valid_in_o <= dv_next;
            pixel_bus_in_o <= take ? buf_data : {PIX_W{1'b0}};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Buffer: blanking stalls the drain side so the producer sees back-pressure.
   // The drain pops only on a pixel slot, so it runs at the pixel rate while the
   // producer side may burst at the full clock rate until both entries fill.
   pvs_buf2 #(
      .W(PIX_W)
   ) u_buf (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(pix_valid_i),
      .in_ready_o(pix_ready_o),
      .in_data_i(pix_data_i),
      .out_valid_o(buf_valid),
      .out_ready_i(pix_en & dv_next),
      .out_data_o(buf_data)
   );
endmodule : pvs_video_source
`default_nettype wire

// ===== dv/pvs_video_source_checker.sv
// Concurrent checks on the link pins of the parallel video source.
`default_nettype none
module pvs_video_source_checker
   import pvs_pkg::*;
#(
   parameter int EYE_HOLD_CYC = EYE_GUARD_CYC
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic pclk_o,
   input wire logic vsync_o,
   input wire logic hsync_o,
   input wire logic pixel_valid_in_o,
   input wire logic [PIX_W-1:0] pixel_bus_in_o,
   input wire logic stereo_eye_select_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   int line_reg;
   int vs_age_reg;
   int eye_age_reg;
   logic seen_reg;
   ////////////////////////////////////////////////////////////////////////////////
   // Line index in the frame and saturating ages of the last sync and eye edges.
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         line_reg <= 0;
         vs_age_reg <= EYE_HOLD_CYC;
         eye_age_reg <= EYE_HOLD_CYC;
         seen_reg <= 1'h0;
      end
      else
      begin
         if ($rose(hsync_o))
            line_reg <= $rose(vsync_o) ? 0 : line_reg + 1;
         seen_reg <= seen_reg | $rose(vsync_o);
         vs_age_reg <= $changed(vsync_o) ? 0 : vs_age_reg + int'(vs_age_reg < EYE_HOLD_CYC);
         eye_age_reg <= $changed(stereo_eye_select_o) ? 0 :
            eye_age_reg + int'(eye_age_reg < EYE_HOLD_CYC);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One pixel clock is four reference clocks, so 8 pclk is 32 and a line is 144.
   sequence s_hs_pulse;
      ##31 hsync_o ##1 !hsync_o;
   endsequence
   sequence s_vs_pulse;
      ##143 vsync_o ##1 !vsync_o;
   endsequence
   a_pins_on_fall: assert property (!$fell(pclk_o) |-> $stable(hsync_o) && $stable(vsync_o) &&
      $stable(pixel_valid_in_o) && $stable(pixel_bus_in_o)) else $error("pins moved off pclk fall");
   a_vs_width: assert property ($rose(vsync_o) |-> s_vs_pulse) else $error("vsync width");
   a_vs_back: assert property ($rose(pixel_valid_in_o) |-> line_reg >= V_BP &&
      line_reg < V_BP + V_ACTIVE) else $error("active line outside window");
   a_vs_front: assert property ($rose(vsync_o) && seen_reg |->
      line_reg == V_BP + V_ACTIVE + V_FP - 1) else $error("frame length");
   a_blank_total: assert property ($rose(vsync_o) && seen_reg |->
      line_reg + 1 - V_ACTIVE >= V_BLANK_MIN) else $error("blanking short");
   a_hs_width: assert property ($rose(hsync_o) |-> s_hs_pulse) else $error("hsync width");
   a_h_back: assert property ($rose(pixel_valid_in_o) |-> $past(hsync_o, 17) &&
      !$past(hsync_o, 16)) else $error("horizontal back porch");
   a_h_front: assert property ($fell(pixel_valid_in_o) |-> ##32 $rose(hsync_o))
      else $error("horizontal front porch");
   // Two cycles of slack cover where the design starts its own guard count.
   a_eye_setup: assert property ($changed(vsync_o) |-> eye_age_reg >= EYE_HOLD_CYC - 2)
      else $error("eye select too close before sync");
   a_eye_hold: assert property ($changed(stereo_eye_select_o) |->
      vs_age_reg >= EYE_HOLD_CYC - 2) else $error("eye select too close after sync");
endmodule : pvs_video_source_checker
bind pvs_video_source pvs_video_source_checker #(.EYE_HOLD_CYC(EYE_HOLD_CYC)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pclk_o(pclk_o), .vsync_o(vsync_o),
   .hsync_o(hsync_o), .pixel_valid_in_o(pixel_valid_in_o), .pixel_bus_in_o(pixel_bus_in_o),
   .stereo_eye_select_o(stereo_eye_select_o));
`default_nettype wire

// ===== dv/pvs_sink_model.sv
// Display input model: samples the link on the pixel clock rise and counts lines.
`default_nettype none
module pvs_sink_model
   import pvs_pkg::*;
(
   input wire logic pclk_i,
   input wire logic vsync_i,
   input wire logic pixel_valid_in_i,
   input wire logic [PIX_W-1:0] pixel_bus_in_i,
   output logic [31:0] lines_o,
   output logic [31:0] px_cnt_o,
   output logic [PIX_W-1:0] last_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic vs_q = 1'h0;
   logic dv_q = 1'h0;
   logic [31:0] act_cnt = 32'h0000_0000;
   initial
   begin
      lines_o = 32'h0000_0000;
      px_cnt_o = 32'h0000_0000;
      last_o = 24'h00_0000;
   end
   // Only the rising edge is looked at, so a pin that moves on it would be a race.
   always @(posedge pclk_i)
   begin
      vs_q <= vsync_i;
      dv_q <= pixel_valid_in_i;
      if (vsync_i && !vs_q)
      begin
         lines_o <= act_cnt;
         act_cnt <= 32'h0000_0000;
      end
      else if (pixel_valid_in_i && !dv_q)
         act_cnt <= act_cnt + 32'h0000_0001;
      if (pixel_valid_in_i)
      begin
         px_cnt_o <= px_cnt_o + 32'h0000_0001;
         last_o <= pixel_bus_in_i;
      end
   end
endmodule : pvs_sink_model
`default_nettype wire

// ===== dv/pvs_video_source_tb.sv
// Self-checking bench for the parallel video source.
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pvs_video_source_tb
   import pvs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'h0, rst_n_i = 1'h0, enable_i = 1'h0, eye_select_i = 1'h0;
   logic pix_valid_i = 1'h0, took = 1'h0;
   logic [PIX_W-1:0] pix_data_i = 24'h00_0001;
   logic pix_ready_o, pclk_o, vsync_o, hsync_o, pixel_valid_in_o, stereo_eye_select_o, underrun_o;
   logic [PIX_W-1:0] pixel_bus_in_o, last;
   logic [31:0] lines, px_cnt;
   int mismatches = 0, cmp_count = 0, cycles = 0, wi;
   // Short eye guard so the guard paths are reached within a few frames.
   localparam int EYE_HOLD_TB = 40;
   pvs_video_source #(.EYE_HOLD_CYC(EYE_HOLD_TB)) DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .enable_i(enable_i), .eye_select_i(eye_select_i), .pix_valid_i(pix_valid_i),
      .pix_ready_o(pix_ready_o), .pix_data_i(pix_data_i), .pclk_o(pclk_o), .vsync_o(vsync_o),
      .hsync_o(hsync_o), .pixel_valid_in_o(pixel_valid_in_o), .pixel_bus_in_o(pixel_bus_in_o),
      .stereo_eye_select_o(stereo_eye_select_o), .underrun_o(underrun_o));
   pvs_sink_model u_sink (.pclk_i(pclk_o), .vsync_i(vsync_o), .pixel_valid_in_i(pixel_valid_in_o),
      .pixel_bus_in_i(pixel_bus_in_o), .lines_o(lines), .px_cnt_o(px_cnt), .last_o(last));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, a hang limit of about nine frames, and a producer that counts up from one.
   always #10 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   always @(posedge ref_clk_i) took <= pix_valid_i & pix_ready_o;
   always @(negedge ref_clk_i) if (took) pix_data_i <= pix_data_i + 24'h00_0001;
   ////////////////////////////////////////////////////////////////////////////////
   // With the video held off, the buffer takes two words and then refuses.
   task t_refuse;
      pix_valid_i = 1'h1;
      repeat (6) @(negedge ref_clk_i);
      `CHK("ready when full", 1'h0, pix_ready_o)
   endtask : t_refuse
   // Two frames go out; word k must land on pixel k and eight lines must carry data.
   task t_frames;
      enable_i = 1'h1;
      for (wi = 0; wi < 12000 && px_cnt < 32'd256; wi++) @(negedge ref_clk_i);
      `CHK("active lines", 32'(V_ACTIVE), lines)
      `CHK("pixel order", px_cnt, {8'h00, last})
   endtask : t_frames
   // A starved producer must show a one-cycle underrun and a zero word on the bus.
   task t_underrun;
      pix_valid_i = 1'h0;
      for (wi = 0; wi < 5000 && underrun_o !== 1'h1; wi++) @(negedge ref_clk_i);
      `CHK("underrun", 1'h1, underrun_o)
      @(negedge ref_clk_i);
      `CHK("underrun pulse", 1'h0, underrun_o)
      repeat (8) @(negedge ref_clk_i);
      `CHK("zero word", 24'h00_0000, last)
      pix_valid_i = 1'h1;
   endtask : t_underrun
   // The eye flag must follow the request in both directions while frames run.
   task t_eye;
      eye_select_i = 1'h1;
      for (wi = 0; wi < 10000 && stereo_eye_select_o !== 1'h1; wi++) @(negedge ref_clk_i);
      `CHK("eye set", 1'h1, stereo_eye_select_o)
      eye_select_i = 1'h0;
      for (wi = 0; wi < 10000 && stereo_eye_select_o !== 1'h0; wi++) @(negedge ref_clk_i);
      `CHK("eye clear", 1'h0, stereo_eye_select_o)
   endtask : t_eye
   // An eye request at the sync rise must wait out the sync line, and a frame
   // may not start until a fresh eye value has stood for the guard time.
   task t_eye_guard;
      for (wi = 0; wi < 6000 && vsync_o !== 1'h1; wi++) @(negedge ref_clk_i);
      eye_select_i = 1'h1;
      repeat (100) @(negedge ref_clk_i);
      `CHK("eye held in sync", 1'h0, stereo_eye_select_o)
      for (wi = 0; wi < 400 && stereo_eye_select_o !== 1'h1; wi++) @(negedge ref_clk_i);
      `CHK("eye after sync", 1'h1, stereo_eye_select_o)
      `CHK("eye sync low", 1'h0, vsync_o)
      enable_i = 1'h0;
      repeat (4400) @(negedge ref_clk_i);
      eye_select_i = 1'h0;
      for (wi = 0; wi < 100 && stereo_eye_select_o !== 1'h0; wi++) @(negedge ref_clk_i);
      enable_i = 1'h1;
      for (wi = 0; wi < 200 && vsync_o !== 1'h1; wi++) @(negedge ref_clk_i);
      `CHK("frame start after eye", 1'h1, wi > EYE_HOLD_TB && wi <= EYE_HOLD_TB + 4)
   endtask : t_eye_guard
   task end_of_test;
      if (mismatches == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   // Reset for eight cycles, then the scenarios in turn.
   initial
   begin
      repeat (8) @(negedge ref_clk_i);
      rst_n_i = 1'h1;
      t_refuse();
      t_frames();
      t_underrun();
      t_eye();
      t_eye_guard();
      end_of_test();
   end
endmodule : pvs_video_source_tb
`default_nettype wire
